// >>> include/cjale_consts.svh
// Constants for the call, jump, add and conjunction execution slice
`ifndef CJALE_CONSTS_SVH
`define CJALE_CONSTS_SVH
`define CJALE_OP_PAGE_CALL_LO 5'h11
`define CJALE_OP_PAGE_JUMP_LO 5'h01
`define CJALE_OP_ADD_REG_HI   5'h05
`define CJALE_OP_ADD_IND_HI   7'h13
`define CJALE_OP_ADD_DIR      8'h25
`define CJALE_OP_ADD_IMM      8'h24
`define CJALE_OP_ADC_REG_HI   5'h07
`define CJALE_OP_ADC_IND_HI   7'h1b
`define CJALE_OP_ADC_DIR      8'h35
`define CJALE_OP_ADC_IMM      8'h34
`define CJALE_OP_AND_REG_HI   5'h0b
`define CJALE_OP_AND_IND_HI   7'h2b
`define CJALE_OP_AND_DIR      8'h55
`define CJALE_OP_AND_IMM      8'h54
`define CJALE_OP_AND_DIR_A    8'h52
`define CJALE_OP_AND_DIR_IMM  8'h53
`define CJALE_PC_STEP         16'h0002
`define CJALE_SP_STEP         8'h01
`define CJALE_DIRECT_RAM_TOP  8'h80
`define CJALE_BIT_RAM_TOP     8'h80
`define CJALE_RST_PC          16'h0000
`define CJALE_RST_SP          8'h07
`define CJALE_RST_ACC         8'h00
`endif

// >>> include/cjale_pkg.sv
// Types for the call, jump, add and conjunction execution slice
package cjale_pkg;
    typedef enum logic [2:0] {
        CJALE_IDLE,
        CJALE_PUSH_LO,
        CJALE_PUSH_HI,
        CJALE_JUMP_WAIT,
        CJALE_DIR_AND_WR
    } cjale_state_e;
    typedef enum logic [1:0] {
        CJALE_SRC_REG,
        CJALE_SRC_IND,
        CJALE_SRC_DIR,
        CJALE_SRC_IMM
    } cjale_src_e;
endpackage

// >>> src/cjale_exec.sv
// Execution slice: page call/jump, byte add, add with carry, byte AND
// Operation
// - Direct address byte reaches low RAM, registers
// - Bit address covers flags and addressable bits
// - Opcode low bit picks pointer register address
// - Sixteen-bit constant from bytes two, three
// - Relative offset signed, from next instruction
// - Long targets are full sixteen-bit addresses
// - Page call pushes low then high
// - Call target: PC top, opcode bits, byte
// - Page call opcode low bits 10001
// - Page jump replaces low eleven PC bits
// - Page jump opcode 00001, two cycles
// - Add sets carry, half-carry from bits
// - Signed-range flag from bit six/seven carries
// - Register and pointer adds: one byte
// - Direct and immediate adds: two bytes
// - Add with carry includes carry flag
// - Add with carry opcodes, one cycle
// - Add with carry immediate, two bytes
// - Byte AND changes no flag except parity
// - Six operand combinations for byte AND
// - Port AND reads output latch
// - Register AND opcode 01011rrr
// - Parity follows accumulator after each change
`timescale 1ns/1ps
`include "cjale_consts.svh"
module cjale_exec (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    input  wire logic        i_valid,
    input  wire logic [7:0]  i_opcode,
    input  wire logic [7:0]  i_byte2,
    input  wire logic [7:0]  i_byte3,
    input  wire logic [15:0] i_program_counter,
    input  wire logic [7:0]  i_working_register,
    input  wire logic [7:0]  i_pointer_register_0,
    input  wire logic [7:0]  i_pointer_register_1,
    input  wire logic [7:0]  i_ind_data,
    input  wire logic [7:0]  i_dir_data,
    input  wire logic        i_dir_is_port,
    input  wire logic [7:0]  i_port_latch,
    output logic             o_busy,
    output logic             o_done,
    output logic [15:0]      o_program_counter,
    output logic             o_pc_load,
    output logic [7:0]       o_stack_pointer,
    output logic [7:0]       o_acc,
    output logic             o_carry_flag,
    output logic             o_half_carry_flag,
    output logic             o_signed_range_flag,
    output logic             o_parity_flag,
    output logic             o_mem_we,
    output logic [7:0]       o_mem_addr,
    output logic [7:0]       o_mem_wdata,
    output logic [2:0]       o_reg_sel,
    output logic [7:0]       o_ind_addr,
    output logic             o_ind_low_ram,
    output logic             o_dir_low_ram,
    output logic             o_pass,
    output logic [7:0]       o_pass_opcode,
    output logic [15:0]      o_imm16,
    output logic [15:0]      o_rel_target,
    output logic             o_bit_in_ram
);
    import cjale_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    cjale_state_e state, next_state;
    logic [15:0]  pc, next_pc;
    logic         pc_load, next_pc_load;
    logic [7:0]   sp, next_sp;
    logic [7:0]   acc, next_acc;
    logic         cy, next_cy;
    logic         ac, next_ac;
    logic         ov, next_ov;
    logic         par, next_par;
    logic         busy, next_busy;
    logic         done, next_done;
    logic         we, next_we;
    logic [7:0]   maddr, next_maddr;
    logic [7:0]   mwdata, next_mwdata;
    logic         pass, next_pass;
    logic [7:0]   pass_op, next_pass_op;
    logic [15:0]  imm16, next_imm16;
    logic [15:0]  rel, next_rel;
    logic [7:0]   ind_addr, next_ind_addr;
    logic         ind_low, next_ind_low;
    logic         dir_low, next_dir_low;
    logic         bit_ram, next_bit_ram;
    logic [2:0]   rsel, next_rsel;
    logic [7:0]   held_wdata, next_held_wdata;

    // ------------------------------------------------------------
    // Decode and arithmetic
    // ------------------------------------------------------------
    logic        is_add;
    logic        is_and_a;
    logic        use_cin;
    cjale_src_e  src_kind;
    logic [7:0]  src;
    logic [7:0]  ptr;
    logic [4:0]  lo_sum;
    logic [7:0]  lo7_sum;
    logic [8:0]  full_sum;
    logic        c6;
    logic [15:0] pc_next_instr;
    logic [7:0]  dir_orig;

    always_comb begin
        is_add   = 1'b0;
        is_and_a = 1'b0;
        src_kind = CJALE_SRC_REG;
        if (i_opcode[7:3] == `CJALE_OP_ADD_REG_HI || i_opcode[7:3] == `CJALE_OP_ADC_REG_HI) begin
            is_add = 1'b1;
        end else if (i_opcode[7:1] == `CJALE_OP_ADD_IND_HI ||
                     i_opcode[7:1] == `CJALE_OP_ADC_IND_HI) begin
            is_add   = 1'b1;
            src_kind = CJALE_SRC_IND;
        end else if (i_opcode == `CJALE_OP_ADD_DIR || i_opcode == `CJALE_OP_ADC_DIR) begin
            is_add   = 1'b1;
            src_kind = CJALE_SRC_DIR;
        end else if (i_opcode == `CJALE_OP_ADD_IMM || i_opcode == `CJALE_OP_ADC_IMM) begin
            is_add   = 1'b1;
            src_kind = CJALE_SRC_IMM;
        end else if (i_opcode[7:3] == `CJALE_OP_AND_REG_HI) begin
            is_and_a = 1'b1;
        end else if (i_opcode[7:1] == `CJALE_OP_AND_IND_HI) begin
            is_and_a = 1'b1;
            src_kind = CJALE_SRC_IND;
        end else if (i_opcode == `CJALE_OP_AND_DIR) begin
            is_and_a = 1'b1;
            src_kind = CJALE_SRC_DIR;
        end else if (i_opcode == `CJALE_OP_AND_IMM) begin
            is_and_a = 1'b1;
            src_kind = CJALE_SRC_IMM;
        end
        use_cin = is_add & i_opcode[4];
        // Pointer 0 or 1 from opcode bit 0
        ptr = i_opcode[0] ? i_pointer_register_1 : i_pointer_register_0;
        case (src_kind)
            CJALE_SRC_REG: src = i_working_register;
            CJALE_SRC_IND: src = i_ind_data;
            CJALE_SRC_DIR: src = i_dir_data;
            CJALE_SRC_IMM: src = i_byte2;
            default:       src = i_byte2;
        endcase
        // Carries from bits 3, 6, 7 computed from partial sums
        lo_sum   = 5'({1'b0, acc[3:0]} + {1'b0, src[3:0]} + {4'h0, use_cin & cy});
        lo7_sum  = 8'({1'b0, acc[6:0]} + {1'b0, src[6:0]} + {7'h00, use_cin & cy});
        full_sum = 9'({1'b0, acc} + {1'b0, src} + {8'h00, use_cin & cy});
        c6       = lo7_sum[7];
        pc_next_instr = 16'(i_program_counter + `CJALE_PC_STEP);
        // Port operands of the direct-destination AND read back from the output latch, not the pins
        dir_orig = i_dir_is_port ? i_port_latch : i_dir_data;
    end

    always_comb begin
        next_state      = state;
        next_pc         = pc;
        next_pc_load    = 1'b0;
        next_sp         = sp;
        next_acc        = acc;
        next_cy         = cy;
        next_ac         = ac;
        next_ov         = ov;
        next_busy       = busy;
        next_done       = 1'b0;
        next_we         = 1'b0;
        next_maddr      = maddr;
        next_mwdata     = mwdata;
        next_pass       = 1'b0;
        next_pass_op    = pass_op;
        next_imm16      = imm16;
        next_rel        = rel;
        next_ind_addr   = ind_addr;
        next_ind_low    = ind_low;
        next_dir_low    = dir_low;
        next_bit_ram    = bit_ram;
        next_rsel       = rsel;
        next_held_wdata = held_wdata;
        case (state)
            CJALE_IDLE: begin
                if (i_valid) begin
                    next_rsel     = i_opcode[2:0];
                    next_ind_addr = ptr;
                    next_ind_low  = ~ptr[7];
                    next_dir_low  = i_byte2 < `CJALE_DIRECT_RAM_TOP;
                    next_bit_ram  = i_byte2 < `CJALE_BIT_RAM_TOP;
                    next_imm16    = {i_byte2, i_byte3};
                    // Sign-extended offset from the following instruction
                    next_rel      = 16'(pc_next_instr + {{8{i_byte2[7]}}, i_byte2});
                    if (i_opcode[4:0] == `CJALE_OP_PAGE_CALL_LO) begin
                        next_pc    = {pc_next_instr[15:11], i_opcode[7:5], i_byte2};
                        next_sp    = 8'(sp + `CJALE_SP_STEP);
                        next_maddr = 8'(sp + `CJALE_SP_STEP);
                        next_mwdata     = pc_next_instr[7:0];
                        next_held_wdata = pc_next_instr[15:8];
                        next_we    = 1'b1;
                        next_busy  = 1'b1;
                        next_state = CJALE_PUSH_LO;
                    end else if (i_opcode[4:0] == `CJALE_OP_PAGE_JUMP_LO) begin
                        next_pc    = {pc_next_instr[15:11], i_opcode[7:5], i_byte2};
                        next_busy  = 1'b1;
                        next_state = CJALE_JUMP_WAIT;
                    end else if (is_add) begin
                        next_acc  = full_sum[7:0];
                        next_cy   = full_sum[8];
                        next_ac   = lo_sum[4];
                        next_ov   = full_sum[8] ^ c6;
                        next_done = 1'b1;
                    end else if (is_and_a) begin
                        next_acc  = acc & src;
                        next_done = 1'b1;
                    end else if (i_opcode == `CJALE_OP_AND_DIR_A ||
                                 i_opcode == `CJALE_OP_AND_DIR_IMM) begin
                        next_maddr  = i_byte2;
                        next_mwdata = dir_orig &
                            ((i_opcode == `CJALE_OP_AND_DIR_A) ? acc : i_byte3);
                        next_we     = 1'b1;
                        next_done   = 1'b1;
                    end else begin
                        // Unknown opcode leaves all architectural state alone
                        next_pass    = 1'b1;
                        next_pass_op = i_opcode;
                    end
                end
            end
            CJALE_PUSH_LO: begin
                next_sp     = 8'(sp + `CJALE_SP_STEP);
                next_maddr  = 8'(sp + `CJALE_SP_STEP);
                next_mwdata = held_wdata;
                next_we     = 1'b1;
                next_state  = CJALE_PUSH_HI;
            end
            CJALE_PUSH_HI: begin
                next_pc_load = 1'b1;
                next_busy    = 1'b0;
                next_done    = 1'b1;
                next_state   = CJALE_IDLE;
            end
            CJALE_JUMP_WAIT: begin
                next_pc_load = 1'b1;
                next_busy    = 1'b0;
                next_done    = 1'b1;
                next_state   = CJALE_IDLE;
            end
            default: begin
                next_busy  = 1'b0;
                next_state = CJALE_IDLE;
            end
        endcase
        next_par = ^next_acc;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state      <= CJALE_IDLE;
            pc         <= `CJALE_RST_PC;
            pc_load    <= 1'b0;
            sp         <= `CJALE_RST_SP;
            acc        <= `CJALE_RST_ACC;
            cy         <= 1'b0;
            ac         <= 1'b0;
            ov         <= 1'b0;
            par        <= 1'b0;
            busy       <= 1'b0;
            done       <= 1'b0;
            we         <= 1'b0;
            maddr      <= 8'h00;
            mwdata     <= 8'h00;
            pass       <= 1'b0;
            pass_op    <= 8'h00;
            imm16      <= 16'h0000;
            rel        <= 16'h0000;
            ind_addr   <= 8'h00;
            ind_low    <= 1'b0;
            dir_low    <= 1'b0;
            bit_ram    <= 1'b0;
            rsel       <= 3'h0;
            held_wdata <= 8'h00;
        end else if (i_ce) begin
            state      <= next_state;
            pc         <= next_pc;
            pc_load    <= next_pc_load;
            sp         <= next_sp;
            acc        <= next_acc;
            cy         <= next_cy;
            ac         <= next_ac;
            ov         <= next_ov;
            par        <= next_par;
            busy       <= next_busy;
            done       <= next_done;
            we         <= next_we;
            maddr      <= next_maddr;
            mwdata     <= next_mwdata;
            pass       <= next_pass;
            pass_op    <= next_pass_op;
            imm16      <= next_imm16;
            rel        <= next_rel;
            ind_addr   <= next_ind_addr;
            ind_low    <= next_ind_low;
            dir_low    <= next_dir_low;
            bit_ram    <= next_bit_ram;
            rsel       <= next_rsel;
            held_wdata <= next_held_wdata;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_busy              = busy;
    assign o_done              = done;
    assign o_program_counter   = pc;
    assign o_pc_load           = pc_load;
    assign o_stack_pointer     = sp;
    assign o_acc               = acc;
    assign o_carry_flag        = cy;
    assign o_half_carry_flag   = ac;
    assign o_signed_range_flag = ov;
    assign o_parity_flag       = par;
    assign o_mem_we            = we;
    assign o_mem_addr          = maddr;
    assign o_mem_wdata         = mwdata;
    assign o_reg_sel           = rsel;
    assign o_ind_addr          = ind_addr;
    assign o_ind_low_ram       = ind_low;
    assign o_dir_low_ram       = dir_low;
    assign o_pass              = pass;
    assign o_pass_opcode       = pass_op;
    assign o_imm16             = imm16;
    assign o_rel_target        = rel;
    assign o_bit_in_ram        = bit_ram;
endmodule // cjale_exec

// >>> verif/cjale_exec_checker.sv
// Assertion checker bound to the execution slice
`timescale 1ns/1ps
module cjale_exec_checker (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_ce,
    input wire logic        i_valid,
    input wire logic [7:0]  i_opcode,
    input wire logic [7:0]  i_byte2,
    input wire logic [7:0]  i_byte3,
    input wire logic [15:0] i_program_counter,
    input wire logic [7:0]  i_working_register,
    input wire logic [7:0]  i_ind_data,
    input wire logic [7:0]  i_dir_data,
    input wire logic        i_dir_is_port,
    input wire logic [7:0]  i_port_latch,
    input wire logic        o_busy,
    input wire logic        o_done,
    input wire logic [15:0] o_program_counter,
    input wire logic        o_pc_load,
    input wire logic [7:0]  o_stack_pointer,
    input wire logic [7:0]  o_acc,
    input wire logic        o_carry_flag,
    input wire logic        o_half_carry_flag,
    input wire logic        o_signed_range_flag,
    input wire logic        o_parity_flag,
    input wire logic        o_mem_we,
    input wire logic [7:0]  o_mem_addr,
    input wire logic [7:0]  o_mem_wdata,
    input wire logic        o_pass
);
    // ----------------------------
    // Decode and expected values
    // ----------------------------
    logic        take, is_call, is_jump, is_add, is_and, is_dir, hnd, cin;
    logic [7:0]  op, src, e_acc, e_and, e_dir, sp_q;
    logic [8:0]  sum, cx;
    logic [2:0]  e_flg, flg;
    logic [15:0] pc2, pc2_q, tgt_q;
    assign take = i_ce && i_valid && !o_busy;
    assign op = i_opcode;
    assign is_call = op[4:0] == 5'h11;
    assign is_jump = op[4:0] == 5'h01;
    assign is_add = op[7:5] == 3'h1 && op[3:2] != 2'h0;
    assign is_and = op[7:4] == 4'h5 && op[3:2] != 2'h0;
    assign is_dir = op[7:1] == 7'h29;
    assign hnd = is_call || is_jump || is_add || is_and || is_dir;
    // Add and conjunction share one source encoding in the low opcode bits
    assign src = op[3] ? i_working_register : op[1] ? i_ind_data : op[0] ? i_dir_data : i_byte2;
    assign cin = op[4] & o_carry_flag;
    assign sum = {1'b0, o_acc} + {1'b0, src} + {8'h00, cin};
    // Carry into each bit falls out of the xor of sum and operands
    assign cx = sum ^ {1'b0, o_acc} ^ {1'b0, src};
    assign e_acc = sum[7:0];
    assign e_flg = {sum[8], cx[4], cx[7] ^ sum[8]};
    assign flg = {o_carry_flag, o_half_carry_flag, o_signed_range_flag};
    assign e_and = o_acc & src;
    assign e_dir = (i_dir_is_port ? i_port_latch : i_dir_data) & (op[0] ? i_byte3 : o_acc);
    assign pc2 = i_program_counter + 16'h0002;
    always_ff @(posedge i_clk) begin
        if (take) begin
            sp_q  <= o_stack_pointer;
            pc2_q <= pc2;
            tgt_q <= {pc2[15:11], op[7:5], i_byte2};
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    add_flags_a: assert property (
        take && is_add |=> o_done && o_acc == $past(e_acc) && flg == $past(e_flg))
        else $error("add result or flags wrong");
    and_acc_a: assert property (
        take && is_and |=> o_done && o_acc == $past(e_and) && $stable(flg))
        else $error("conjunction result or flags wrong");
    dir_and_a: assert property (
        take && is_dir |=> o_mem_we && o_mem_addr == $past(i_byte2)
            && o_mem_wdata == $past(e_dir))
        else $error("direct conjunction write wrong");
    call_push_a: assert property (
        take && is_call |=> (o_busy && o_mem_we && o_mem_addr == sp_q + 8'h01
            && o_mem_wdata == pc2_q[7:0]) ##1 (o_mem_we && o_mem_addr == sp_q + 8'h02
            && o_mem_wdata == pc2_q[15:8]))
        else $error("return address push wrong");
    call_target_a: assert property (
        take && is_call |-> ##3 (o_done && o_pc_load && o_program_counter == tgt_q
            && o_stack_pointer == sp_q + 8'h02))
        else $error("page call target wrong");
    jump_target_a: assert property (
        take && is_jump |=> (o_busy && !o_pc_load)
            ##1 (o_done && o_pc_load && o_program_counter == tgt_q))
        else $error("page jump target or timing wrong");
    pass_hold_a: assert property (
        take && !hnd |=> o_pass && !o_mem_we && $stable(o_acc) && $stable(o_stack_pointer))
        else $error("unhandled opcode altered state");
    parity_acc_a: assert property (
        o_parity_flag == ^o_acc)
        else $error("parity does not follow accumulator");
    call_seen_c: cover property (take && is_call);
    jump_seen_c: cover property (take && is_jump);
    port_and_c: cover property (take && is_dir && i_dir_is_port);
    pass_seen_c: cover property (take && !hnd);
endmodule // cjale_exec_checker

bind cjale_exec cjale_exec_checker u_cjale_exec_checker (
    .i_clk, .i_rst, .i_ce, .i_valid, .i_opcode, .i_byte2, .i_byte3, .i_program_counter,
    .i_working_register, .i_ind_data, .i_dir_data, .i_dir_is_port, .i_port_latch, .o_busy,
    .o_done, .o_program_counter, .o_pc_load, .o_stack_pointer, .o_acc, .o_carry_flag,
    .o_half_carry_flag, .o_signed_range_flag, .o_parity_flag, .o_mem_we, .o_mem_addr,
    .o_mem_wdata, .o_pass
);

// >>> verif/cjale_mem_model.sv
// Behavioural model of the internal data memory
`timescale 1ns/1ps
module cjale_mem_model (
    input  wire logic       i_clk,
    input  wire logic       i_we,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic [7:0] i_opcode,
    input  wire logic [7:0] i_dir_addr,
    output logic [7:0]      o_ptr0,
    output logic [7:0]      o_ptr1,
    output logic [7:0]      o_reg,
    output logic [7:0]      o_ind,
    output logic [7:0]      o_dir
);
    logic [7:0] mem [0:255];
    // Bank 0 only; bank switching lives outside this slice
    assign o_ptr0 = mem[0];
    assign o_ptr1 = mem[1];
    assign o_reg = mem[{5'h00, i_opcode[2:0]}];
    assign o_ind = mem[i_opcode[0] ? o_ptr1 : o_ptr0];
    assign o_dir = mem[i_dir_addr];
    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
    end
endmodule // cjale_mem_model

// >>> verif/testbench.sv
// Self-checking testbench for the execution slice
`timescale 1ns/1ps
module testbench;
    logic        i_clk, i_rst, i_ce, i_valid, i_dir_is_port, o_busy, o_done, o_pc_load;
    logic        o_carry_flag, o_half_carry_flag, o_signed_range_flag, o_parity_flag;
    logic        o_mem_we, o_pass, o_ind_low_ram, o_dir_low_ram, o_bit_in_ram;
    logic [2:0]  o_reg_sel;
    logic [7:0]  i_opcode, i_byte2, i_byte3, i_port_latch, i_working_register;
    logic [7:0]  i_pointer_register_0, i_pointer_register_1, i_ind_data, i_dir_data;
    logic [7:0]  o_stack_pointer, o_acc, o_mem_addr, o_mem_wdata, o_pass_opcode, o_ind_addr;
    logic [15:0] i_program_counter, o_program_counter, o_imm16, o_rel_target;
    int          errors, num_checks;
    cjale_exec u_cjale_exec (
        .i_clk, .i_rst, .i_ce, .i_valid, .i_opcode, .i_byte2, .i_byte3, .i_program_counter,
        .i_working_register, .i_pointer_register_0, .i_pointer_register_1, .i_ind_data,
        .i_dir_data, .i_dir_is_port, .i_port_latch, .o_busy, .o_done, .o_program_counter,
        .o_pc_load, .o_stack_pointer, .o_acc, .o_carry_flag, .o_half_carry_flag,
        .o_signed_range_flag, .o_parity_flag, .o_mem_we, .o_mem_addr, .o_mem_wdata,
        .o_reg_sel, .o_ind_addr, .o_ind_low_ram, .o_dir_low_ram, .o_pass,
        .o_pass_opcode, .o_imm16, .o_rel_target, .o_bit_in_ram
    );
    cjale_mem_model u_cjale_mem_model (
        .i_clk, .i_we(o_mem_we), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_opcode,
        .i_dir_addr(i_byte2), .o_ptr0(i_pointer_register_0), .o_ptr1(i_pointer_register_1),
        .o_reg(i_working_register), .o_ind(i_ind_data), .o_dir(i_dir_data)
    );
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait for completion or pass-through; n counts extra cycles
    task automatic run(input logic [7:0] o, b, c, output int n);
        @(negedge i_clk);
        i_opcode = o;
        i_byte2 = b;
        i_byte3 = c;
        i_valid = 1'b1;
        @(negedge i_clk);
        i_valid = 1'b0;
        n = 0;
        while (o_done !== 1'b1 && o_pass !== 1'b1 && n < 8) begin
            @(negedge i_clk);
            n++;
        end
        if (n == 8) begin
            errors++;
            final_report();
        end
    endtask
    task automatic step(input logic [7:0] o, b, c, ea, input logic [2:0] ef);
        int n;
        run(o, b, c, n);
        chk(16'(o_acc), 16'(ea));
        chk(16'({o_carry_flag, o_half_carry_flag, o_signed_range_flag}), 16'(ef));
        chk(16'(o_parity_flag), 16'(^ea));
        chk(16'(n), 16'h0000);
    endtask
    task automatic xfer(input logic [15:0] p, t, input logic [7:0] o, b, s, input int w);
        int          n;
        logic [15:0] r;
        r = p + 16'h0002;
        i_program_counter = p;
        chk(16'(o_stack_pointer), 16'(s));
        run(o, b, 8'h00, n);
        chk(16'(n), 16'(w));
        chk(16'(o_pc_load), 16'h0001);
        chk(o_program_counter, t);
        chk(16'(o_stack_pointer), 16'(o[4] ? s + 8'h02 : s));
        @(negedge i_clk);
        if (o[4]) begin
            chk(16'(u_cjale_mem_model.mem[s + 8'h01]), 16'(r[7:0]));
            chk(16'(u_cjale_mem_model.mem[s + 8'h02]), 16'(r[15:8]));
        end
    endtask
    task automatic t_add();
        i_program_counter = 16'h1234;
        step(8'h24, 8'hc3, 8'h5a, 8'hc3, 3'b000);
        chk(o_imm16, 16'hc35a);
        chk(o_rel_target, 16'h11f9);
        step(8'h28, 8'h00, 8'h00, 8'h6d, 3'b101);
        step(8'h25, 8'h30, 8'h00, 8'h00, 3'b110);
        chk(16'({o_dir_low_ram, o_bit_in_ram}), 16'h0003);
        step(8'h34, 8'hc3, 8'h00, 8'hc4, 3'b000);
        step(8'h38, 8'h00, 8'h00, 8'h6e, 3'b101);
        step(8'h35, 8'h30, 8'h00, 8'h02, 3'b110);
        step(8'h37, 8'h00, 8'h00, 8'h82, 3'b011);
        chk(16'({o_ind_addr, o_reg_sel, o_ind_low_ram}), 16'h040f);
        $display("add tests done");
    endtask
    task automatic t_and();
        step(8'h5b, 8'h00, 8'h00, 8'h82, 3'b011);
        step(8'h56, 8'h00, 8'h00, 8'h82, 3'b011);
        chk(16'({o_ind_addr, o_ind_low_ram}), 16'h0154);
        step(8'h55, 8'h31, 8'h00, 8'h82, 3'b011);
        step(8'h54, 8'h0f, 8'h00, 8'h02, 3'b011);
        step(8'h52, 8'h30, 8'h00, 8'h02, 3'b011);
        @(negedge i_clk);
        chk(16'(u_cjale_mem_model.mem[8'h30]), 16'h0002);
        i_dir_is_port = 1'b1;
        step(8'h53, 8'h90, 8'h3c, 8'h02, 3'b011);
        chk(16'({o_dir_low_ram, o_bit_in_ram}), 16'h0000);
        i_dir_is_port = 1'b0;
        @(negedge i_clk);
        chk(16'(u_cjale_mem_model.mem[8'h90]), 16'h001c);
        $display("conjunction tests done");
    endtask
    task automatic t_page();
        xfer(16'h0123, 16'h0345, 8'h71, 8'h45, 8'h07, 2);
        xfer(16'h07fe, 16'h0810, 8'h11, 8'h10, 8'h09, 2);
        xfer(16'h0345, 16'h0123, 8'h21, 8'h23, 8'h0b, 1);
        xfer(16'h0ffe, 16'h17ff, 8'he1, 8'hff, 8'h0b, 1);
        $display("page transfer tests done");
    endtask
    task automatic t_pass();
        int n;
        run(8'he4, 8'h00, 8'h00, n);
        chk(16'(o_pass), 16'h0001);
        chk(16'(o_pass_opcode), 16'h00e4);
        chk(16'(o_acc), 16'h0002);
        chk(16'(o_stack_pointer), 16'h000b);
        $display("pass-through test done");
    endtask
    initial begin
        errors = 0;
        num_checks = 0;
        {i_rst, i_ce, i_valid, i_dir_is_port} = 4'b1100;
        {i_opcode, i_byte2, i_byte3, i_port_latch} = 32'h0000005f;
        i_program_counter = 16'h0000;
        for (int k = 0; k < 256; k++) u_cjale_mem_model.mem[k] = 8'h00;
        u_cjale_mem_model.mem[8'h00] = 8'haa;
        u_cjale_mem_model.mem[8'h01] = 8'h40;
        u_cjale_mem_model.mem[8'h03] = 8'hff;
        u_cjale_mem_model.mem[8'h30] = 8'h93;
        u_cjale_mem_model.mem[8'h31] = 8'h8e;
        u_cjale_mem_model.mem[8'h40] = 8'h7f;
        u_cjale_mem_model.mem[8'haa] = 8'hf2;
        repeat (2) @(negedge i_clk);
        i_rst = 1'b0;
        t_add();
        t_and();
        t_page();
        t_pass();
        final_report();
    end
endmodule // testbench
